/* File: uvqt_pkg.sv */
package uvqt_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES_DFLT = (TICK_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Setting sets and their fields
  localparam int N_SETS = 4;
  localparam int SET_W = 2;
  localparam int FLD_W = 3;
  localparam logic [2:0] FLD_VTHR = 3'h0;
  localparam logic [2:0] FLD_ITHR = 3'h1;
  localparam logic [2:0] FLD_QTHR = 3'h2;
  localparam logic [2:0] FLD_DLY1 = 3'h3;
  localparam logic [2:0] FLD_DLY2 = 3'h4;
  localparam logic [2:0] FLD_RST1 = 3'h5;
  localparam logic [2:0] FLD_RST2 = 3'h6;

  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_SET_SEL = 8'h10;
  localparam logic [2:0] ADDR_SET_PAGE = 3'h1;

  // Control register layout
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SIGN_BIT = 1;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_SET_LSB = 4;
  localparam int CTRL_BLK_LSB = 16;
  localparam int BLK_W = 14;
  localparam logic SIGN_LOAD = 1'b0;
  localparam logic SIGN_GEN = 1'b1;
  localparam logic SRC_CT1 = 1'b0;
  localparam logic SRC_CT2 = 1'b1;

  // Status register layout
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_BLOCKED_BIT = 1;
  localparam int ST_PICKUP_BIT = 2;
  localparam int ST_TRIP1_BIT = 3;
  localparam int ST_TRIP2_BIT = 4;
  localparam int ST_SRCERR_BIT = 5;

  // Interrupt events
  localparam int IRQ_W = 4;
  localparam int IRQ_PICKUP_BIT = 0;
  localparam int IRQ_TRIP1_BIT = 1;
  localparam int IRQ_TRIP2_BIT = 2;
  localparam int IRQ_BLOCK_BIT = 3;

  // Reset values; thresholds in 0.1 % of nominal, delays in ms
  localparam logic [15:0] VTHR_RST = 16'h0352;
  localparam logic [15:0] ITHR_RST = 16'h0064;
  localparam logic [15:0] QTHR_RST = 16'h0032;
  localparam logic [31:0] DLY1_RST = 32'h0000_03e8;
  localparam logic [31:0] DLY2_RST = 32'h0000_05dc;
  localparam logic [31:0] RST1_RST = 32'h0000_03e8;
  localparam logic [31:0] RST2_RST = 32'h0000_03e8;

  typedef struct packed {
    logic [15:0] u_ab;
    logic [15:0] u_bc;
    logic [15:0] u_ca;
    logic [15:0] i1;
    logic signed [15:0] q1;
  } uvqt_meas_t;

  typedef struct packed {
    logic [15:0] v_thr;
    logic [15:0] i_thr;
    logic [15:0] q_thr;
    logic [31:0] dly1;
    logic [31:0] dly2;
    logic [31:0] rst1;
    logic [31:0] rst2;
  } uvqt_set_t;

  typedef struct packed {
    logic active;
    logic blocked;
    logic pickup;
    logic trip1;
    logic trip2;
  } uvqt_flags_t;

  localparam uvqt_set_t SET_RST = '{VTHR_RST, ITHR_RST, QTHR_RST,
                                    DLY1_RST, DLY2_RST, RST1_RST, RST2_RST};

endpackage

/* File: uvqt_timer.sv */
module uvqt_timer import uvqt_pkg::*; #(
  parameter int W = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic [W-1:0] limit_in,
  output logic expired_out
);

  logic [W-1:0] cnt;

  // Counts time-base ticks while running, restarts from zero when stopped
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else if (!run_in) begin
      cnt <= '0;
    end else if (tick_in && (cnt < limit_in)) begin
      cnt <= cnt + 1'b1;
    end
  end

  // Expiry only while running; zero limit expires at once
  assign expired_out = run_in && (cnt >= limit_in);

endmodule // uvqt_timer

/* File: uvqt_setmem.sv */
module uvqt_setmem import uvqt_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [SET_W-1:0] wr_set_in,
  input wire logic [FLD_W-1:0] wr_fld_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [SET_W-1:0] rd_set_in,
  input wire logic [FLD_W-1:0] rd_fld_in,
  output logic [31:0] rd_data_out,
  input wire logic [SET_W-1:0] act_set_in,
  output uvqt_set_t act_cfg_out
);

  uvqt_set_t sets [N_SETS];

  // Field of one set, thresholds zero-extended
  function automatic logic [31:0] fld_get(input uvqt_set_t s, input logic [FLD_W-1:0] f);
    case (f)
      FLD_VTHR: fld_get = {16'h0000, s.v_thr};
      FLD_ITHR: fld_get = {16'h0000, s.i_thr};
      FLD_QTHR: fld_get = {16'h0000, s.q_thr};
      FLD_DLY1: fld_get = s.dly1;
      FLD_DLY2: fld_get = s.dly2;
      FLD_RST1: fld_get = s.rst1;
      FLD_RST2: fld_get = s.rst2;
      default: fld_get = 32'h0000_0000;
    endcase
  endfunction

  // Storage of the four sets
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int k = 0; k < N_SETS; k++) begin
        sets[k] <= SET_RST;
      end
    end else if (wr_en_in) begin
      case (wr_fld_in)
        FLD_VTHR: sets[wr_set_in].v_thr <= wr_data_in[15:0];
        FLD_ITHR: sets[wr_set_in].i_thr <= wr_data_in[15:0];
        FLD_QTHR: sets[wr_set_in].q_thr <= wr_data_in[15:0];
        FLD_DLY1: sets[wr_set_in].dly1 <= wr_data_in;
        FLD_DLY2: sets[wr_set_in].dly2 <= wr_data_in;
        FLD_RST1: sets[wr_set_in].rst1 <= wr_data_in;
        FLD_RST2: sets[wr_set_in].rst2 <= wr_data_in;
        default: ;
      endcase
    end
  end

  // Registered read ports
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 32'h0000_0000;
      act_cfg_out <= SET_RST;
    end else begin
      rd_data_out <= fld_get(sets[rd_set_in], rd_fld_in);
      act_cfg_out <= sets[act_set_in];
    end
  end

endmodule // uvqt_setmem

/* File: uvqt_top.sv */
module uvqt_top import uvqt_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
  parameter int N_EVENTS = 16
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire uvqt_meas_t MEAS_IN,
  input wire logic [N_EVENTS-1:0] EVENT_IN,
  output logic [31:0] REG_RDATA_OUT,
  output uvqt_flags_t FLAGS_OUT,
  output logic IRQ_OUT
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // Control state
  logic element_enable;
  logic sign_convention_select;
  logic power_source_select;
  logic [SET_W-1:0] act_set;
  logic [BLK_W-1:0] block_source_select;
  logic [SET_W-1:0] bus_set;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_stat;

  // Element state
  logic [N_EVENTS-1:0] ev_meta;
  logic [N_EVENTS-1:0] ev_sync;
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic blk_hit;
  logic live;
  logic src_ok;
  logic u_low;
  logic i_high;
  logic q_ok;
  logic next_pickup;
  logic pickup_flag;
  logic module_active_flag;
  logic module_blocked_flag;
  logic [1:0] trip;
  logic [1:0] next_trip;
  logic [1:0] dly_run;
  logic [1:0] dly_exp;
  logic [1:0] rst_run;
  logic [1:0] rst_exp;
  logic [1:0] dly_zero;
  logic [1:0] rst_zero;
  logic [31:0] dly_lim [2];
  logic [31:0] rst_lim [2];
  logic [IRQ_W-1:0] irq_ev;
  uvqt_set_t cfg;

  // Bus decode
  logic wr_ctrl;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic wr_set_sel;
  logic set_hit;
  logic [31:0] rd_reg;
  logic rd_from_mem;
  logic [31:0] mem_rdata;

  // Register of a setting word: page 1, fields 0 to 6, aligned
  function automatic logic is_set_addr(input logic [ADDR_W-1:0] a);
    is_set_addr = (a[7:5] == ADDR_SET_PAGE) && (a[4:2] <= FLD_RST2) && (a[1:0] == 2'b00);
  endfunction

  // Blocking event lookup; zero or out of range selects nothing
  function automatic logic ev_pick(input logic [N_EVENTS-1:0] ev, input logic [BLK_W-1:0] sel);
    ev_pick = 1'b0;
    for (int k = 0; k < N_EVENTS; k++) begin
      if (sel == BLK_W'(k + 1)) begin
        ev_pick = ev[k];
      end
    end
  endfunction

  assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == ADDR_CTRL);
  assign wr_irq_stat = REG_WR_IN && (REG_ADDR_IN == ADDR_IRQ_STAT);
  assign wr_irq_mask = REG_WR_IN && (REG_ADDR_IN == ADDR_IRQ_MASK);
  assign wr_set_sel = REG_WR_IN && (REG_ADDR_IN == ADDR_SET_SEL);
  assign set_hit = is_set_addr(REG_ADDR_IN);

  // Control register
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      element_enable <= 1'b0;
      sign_convention_select <= SIGN_LOAD;
      power_source_select <= SRC_CT1;
      act_set <= '0;
      block_source_select <= '0;
    end else if (wr_ctrl) begin
      element_enable <= REG_WDATA_IN[CTRL_EN_BIT];
      sign_convention_select <= REG_WDATA_IN[CTRL_SIGN_BIT];
      power_source_select <= REG_WDATA_IN[CTRL_SRC_BIT];
      act_set <= REG_WDATA_IN[CTRL_SET_LSB +: SET_W];
      block_source_select <= REG_WDATA_IN[CTRL_BLK_LSB +: BLK_W];
    end
  end

  // Set selector and interrupt mask
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bus_set <= '0;
      irq_mask <= '0;
    end else begin
      if (wr_set_sel) begin
        bus_set <= REG_WDATA_IN[SET_W-1:0];
      end
      if (wr_irq_mask) begin
        irq_mask <= REG_WDATA_IN[IRQ_W-1:0];
      end
    end
  end

  // Setting store: four sets, each holding the settings of both trip stages
  uvqt_setmem u_setmem (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .wr_en_in(REG_WR_IN && set_hit),
    .wr_set_in(bus_set),
    .wr_fld_in(REG_ADDR_IN[4:2]),
    .wr_data_in(REG_WDATA_IN),
    .rd_set_in(bus_set),
    .rd_fld_in(REG_ADDR_IN[4:2]),
    .rd_data_out(mem_rdata),
    .act_set_in(act_set),
    .act_cfg_out(cfg)
  );

  // Register read, answered in the following cycle
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rd_reg <= 32'h0000_0000;
      rd_from_mem <= 1'b0;
    end else begin
      rd_from_mem <= REG_RD_IN && set_hit;
      rd_reg <= 32'h0000_0000;
      if (REG_RD_IN) begin
        case (REG_ADDR_IN)
          ADDR_CTRL: begin
            rd_reg[CTRL_EN_BIT] <= element_enable;
            rd_reg[CTRL_SIGN_BIT] <= sign_convention_select;
            rd_reg[CTRL_SRC_BIT] <= power_source_select;
            rd_reg[CTRL_SET_LSB +: SET_W] <= act_set;
            rd_reg[CTRL_BLK_LSB +: BLK_W] <= block_source_select;
          end
          ADDR_STATUS: begin
            rd_reg[ST_ACTIVE_BIT] <= module_active_flag;
            rd_reg[ST_BLOCKED_BIT] <= module_blocked_flag;
            rd_reg[ST_PICKUP_BIT] <= pickup_flag;
            rd_reg[ST_TRIP1_BIT] <= trip[0];
            rd_reg[ST_TRIP2_BIT] <= trip[1];
            rd_reg[ST_SRCERR_BIT] <= !src_ok;
          end
          ADDR_IRQ_STAT: rd_reg[IRQ_W-1:0] <= irq_stat;
          ADDR_IRQ_MASK: rd_reg[IRQ_W-1:0] <= irq_mask;
          ADDR_SET_SEL: rd_reg[SET_W-1:0] <= bus_set;
          default: ;
        endcase
      end
    end
  end

  assign REG_RDATA_OUT = rd_from_mem ? mem_rdata : rd_reg;

  // Blocking event inputs come from pins: two-stage synchroniser
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ev_meta <= '0;
      ev_sync <= '0;
    end else begin
      ev_meta <= EVENT_IN;
      ev_sync <= ev_meta;
    end
  end

  // Millisecond time base for all delay counters
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  assign tick = (tick_cnt == TICK_LAST);

  // Pickup criteria; measurements and thresholds share 0.1 % of nominal units
  assign blk_hit = (block_source_select != '0) && ev_pick(ev_sync, block_source_select);
  assign live = element_enable && !blk_hit;
  assign src_ok = (power_source_select == SRC_CT1);
  assign u_low = (MEAS_IN.u_ab < cfg.v_thr) && (MEAS_IN.u_bc < cfg.v_thr)
               && (MEAS_IN.u_ca < cfg.v_thr);
  assign i_high = (MEAS_IN.i1 > cfg.i_thr);

  // Reactive criterion by sign convention
  always_comb begin
    q_ok = 1'b0;
    if (sign_convention_select == SIGN_LOAD) begin
      q_ok = (MEAS_IN.q1 > 16'sh0000)
           && ($signed({MEAS_IN.q1[15], MEAS_IN.q1}) > $signed({1'b0, cfg.q_thr}));
    end else begin
      q_ok = (MEAS_IN.q1 < 16'sh0000)
           && ($signed({MEAS_IN.q1[15], MEAS_IN.q1}) < -$signed({1'b0, cfg.q_thr}));
    end
  end

  assign next_pickup = live && src_ok && u_low && i_high && q_ok;

  // Element flags
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pickup_flag <= 1'b0;
      module_active_flag <= 1'b0;
      module_blocked_flag <= 1'b0;
    end else begin
      pickup_flag <= next_pickup;
      module_active_flag <= element_enable;
      module_blocked_flag <= blk_hit;
    end
  end

  assign dly_lim[0] = cfg.dly1;
  assign dly_lim[1] = cfg.dly2;
  assign rst_lim[0] = cfg.rst1;
  assign rst_lim[1] = cfg.rst2;

  // Two trip stages, each with delay and reset-delay counters
  for (genvar s = 0; s < 2; s++) begin : g_stage
    assign dly_run[s] = pickup_flag && !trip[s];
    assign rst_run[s] = !pickup_flag && trip[s];

    uvqt_timer u_dly (
      .clk_in(CORE_CLK_IN),
      .rst_in(RST_IN),
      .run_in(dly_run[s]),
      .tick_in(tick),
      .limit_in(dly_lim[s]),
      .expired_out(dly_exp[s])
    );

    uvqt_timer u_rst (
      .clk_in(CORE_CLK_IN),
      .rst_in(RST_IN),
      .run_in(rst_run[s]),
      .tick_in(tick),
      .limit_in(rst_lim[s]),
      .expired_out(rst_exp[s])
    );

    // Counters at zero, watched by the restart checks
    assign dly_zero[s] = (u_dly.cnt == '0);
    assign rst_zero[s] = (u_rst.cnt == '0);

    // Trip set after delay, cleared after reset delay or when inhibited
    always_comb begin
      next_trip[s] = trip[s];
      if (!live) begin
        next_trip[s] = 1'b0;
      end else if (dly_exp[s]) begin
        next_trip[s] = 1'b1;
      end else if (rst_exp[s]) begin
        next_trip[s] = 1'b0;
      end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        trip[s] <= 1'b0;
      end else begin
        trip[s] <= next_trip[s];
      end
    end
  end

  // Interrupt events on rising flags; a new event beats a clear
  assign irq_ev[IRQ_PICKUP_BIT] = next_pickup && !pickup_flag;
  assign irq_ev[IRQ_TRIP1_BIT] = next_trip[0] && !trip[0];
  assign irq_ev[IRQ_TRIP2_BIT] = next_trip[1] && !trip[1];
  assign irq_ev[IRQ_BLOCK_BIT] = blk_hit && !module_blocked_flag;

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_stat <= '0;
    end else if (wr_irq_stat) begin
      irq_stat <= (irq_stat & ~REG_WDATA_IN[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end

  assign IRQ_OUT = |(irq_stat & irq_mask);
  assign FLAGS_OUT = '{module_active_flag, module_blocked_flag, pickup_flag, trip[0], trip[1]};

  // Checks
  sequence s_pick_rise;
    !pickup_flag ##1 pickup_flag;
  endsequence

  sequence s_pick_gone;
    !pickup_flag && live;
  endsequence

  property p_disabled_quiet;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      !element_enable |=> !pickup_flag && !trip[0] && !trip[1] && !module_active_flag;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled element still acting");

  property p_blocked;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      blk_hit |=> module_blocked_flag && !pickup_flag && trip == 2'b00;
  endproperty
  a_blocked: assert property (p_blocked) else $error("block event did not inhibit");

  property p_no_block_zero;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      block_source_select == '0 |=> !module_blocked_flag;
  endproperty
  a_no_block_zero: assert property (p_no_block_zero) else $error("blocked with source zero");

  property p_ct2_none;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      power_source_select == SRC_CT2 |=> !pickup_flag;
  endproperty
  a_ct2_none: assert property (p_ct2_none) else $error("pickup on unsupported source");

  property p_load_sign;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      sign_convention_select == SIGN_LOAD && MEAS_IN.q1 <= 16'sh0000 |=> !pickup_flag;
  endproperty
  a_load_sign: assert property (p_load_sign) else $error("load pickup with Q not positive");

  property p_gen_sign;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      sign_convention_select == SIGN_GEN && MEAS_IN.q1 >= 16'sh0000 |=> !pickup_flag;
  endproperty
  a_gen_sign: assert property (p_gen_sign) else $error("generator pickup with Q not negative");

  property p_pick_all;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      live && src_ok && u_low && i_high && q_ok |=> pickup_flag;
  endproperty
  a_pick_all: assert property (p_pick_all) else $error("pickup missing");

  property p_pick_drop;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      !(u_low && i_high && q_ok) |=> !pickup_flag;
  endproperty
  a_pick_drop: assert property (p_pick_drop) else $error("pickup held after condition lost");

  property p_both_start;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      s_pick_rise ##0 (trip == 2'b00) |-> dly_run == 2'b11 && dly_zero == 2'b11;
  endproperty
  a_both_start: assert property (p_both_start) else $error("delay counters not started");

  property p_trip1_cause;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      $rose(trip[0]) |-> $past(pickup_flag) && $past(dly_exp[0]);
  endproperty
  a_trip1_cause: assert property (p_trip1_cause) else $error("first trip without delay");

  property p_trip2_cause;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      $rose(trip[1]) |-> $past(pickup_flag) && $past(dly_exp[1]);
  endproperty
  a_trip2_cause: assert property (p_trip2_cause) else $error("second trip without delay");

  property p_trip_release(int s);
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      s_pick_gone and trip[s] && rst_exp[s] |=> !trip[s];
  endproperty
  a_trip1_release: assert property (p_trip_release(0)) else $error("first trip not released");
  a_trip2_release: assert property (p_trip_release(1)) else $error("second trip not released");

  property p_trip_keep(int s);
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      pickup_flag && trip[s] && live |=> trip[s] && rst_zero[s];
  endproperty
  a_trip1_keep: assert property (p_trip_keep(0)) else $error("first trip lost on repickup");
  a_trip2_keep: assert property (p_trip_keep(1)) else $error("second trip lost on repickup");

  property p_delay_restart;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      !pickup_flag |-> (dly_run == 2'b00 && dly_exp == 2'b00) ##1 dly_zero == 2'b11;
  endproperty
  a_delay_restart: assert property (p_delay_restart) else $error("delay ran without pickup");

endmodule // uvqt_top

/* File: uvqt_fe.sv */
module uvqt_fe import uvqt_pkg::*; (
  input wire logic clk_in,
  input wire logic [15:0] u_in,
  input wire logic [15:0] i_in,
  input wire logic signed [15:0] q_in,
  input wire logic [1:0] hi_in,
  output uvqt_meas_t meas_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Front end updates once a clock; hi_in lifts one phase to nominal
  always_ff @(posedge clk_in) begin
    meas_out.u_ab <= (hi_in == 2'h1) ? 16'h03e8 : u_in;
    meas_out.u_bc <= (hi_in == 2'h2) ? 16'h03e8 : u_in;
    meas_out.u_ca <= (hi_in == 2'h3) ? 16'h03e8 : u_in;
    meas_out.i1 <= i_in;
    meas_out.q1 <= q_in;
  end
endmodule // uvqt_fe

/* File: testbench.sv */
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench import uvqt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [15:0] u = 16'h0320;
  logic [15:0] i = 16'h00c8;
  logic signed [15:0] q = 16'sh0064;
  logic [1:0] hi = 2'h1;
  logic [15:0] ev = 16'h0;
  logic [31:0] rdat;
  logic irq;
  uvqt_flags_t fl;
  uvqt_meas_t meas;
  int err_total = 0;
  int checked = 0;
  // Fast time base: one tick every 4 cycles
  uvqt_top #(.TICK_CYCLES(4), .N_EVENTS(16)) dut (
    .CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(adr), .REG_WDATA_IN(wd),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .MEAS_IN(meas), .EVENT_IN(ev),
    .REG_RDATA_OUT(rdat), .FLAGS_OUT(fl), .IRQ_OUT(irq));
  uvqt_fe fe (.clk_in(clk), .u_in(u), .i_in(i), .q_in(q), .hi_in(hi), .meas_out(meas));
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task summarize;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(n, e, rdat)
  endtask
  task w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task m(input logic [1:0] h, input logic [15:0] qv);
    @(posedge clk);
    hi <= h;
    q <= qv;
  endtask
  // Defaults, set storage and an unmapped place
  task t_reg;
    rchk("ctrl", 8'h00, 32'h0);
    rchk("vthr", 8'h20, 32'h352);
    wreg(8'h2c, 32'h3);
    wreg(8'h30, 32'h8);
    wreg(8'h34, 32'h3);
    wreg(8'h38, 32'ha);
    rchk("dly2", 8'h30, 32'h8);
    wreg(8'h10, 32'h1);
    wreg(8'h20, 32'h1f4);
    rchk("vthr1", 8'h20, 32'h1f4);
    wreg(8'h10, 32'h0);
    rchk("vthr0", 8'h20, 32'h352);
    rchk("unmap", 8'h40, 32'h0);
  endtask
  // Pickup conditions under both sign conventions
  task t_pick;
    wreg(8'h00, 32'h1);
    m(2'h0, 16'h0064);
    w(4);
    `CHK("active", 1'b1, fl.active)
    `CHK("pick", 1'b1, fl.pickup)
    m(2'h2, 16'h0064);
    w(4);
    `CHK("pick_u", 1'b0, fl.pickup)
    m(2'h0, 16'h0032);
    w(4);
    `CHK("pick_q", 1'b0, fl.pickup)
    wreg(8'h00, 32'h3);
    m(2'h0, 16'hff9c);
    w(4);
    `CHK("pick_g", 1'b1, fl.pickup)
    m(2'h0, 16'h0064);
    w(4);
    `CHK("pick_gp", 1'b0, fl.pickup)
    wreg(8'h00, 32'h1);
  endtask
  // Trip delays, reset delays and re-pickup
  task t_trip;
    m(2'h0, 16'h0064);
    w(4);
    `CHK("t1_early", 1'b0, fl.trip1)
    w(20);
    `CHK("t1", 1'b1, fl.trip1)
    `CHK("t2_early", 1'b0, fl.trip2)
    w(20);
    `CHK("t2", 1'b1, fl.trip2)
    m(2'h1, 16'h0064);
    w(4);
    `CHK("t1_hold", 1'b1, fl.trip1)
    w(20);
    `CHK("t1_clr", 1'b0, fl.trip1)
    `CHK("t2_hold", 1'b1, fl.trip2)
    m(2'h0, 16'h0064);
    w(40);
    m(2'h1, 16'h0064);
    w(26);
    `CHK("t2_restart", 1'b1, fl.trip2)
    w(24);
    `CHK("t2_clr", 1'b0, fl.trip2)
  endtask
  // Sticky status, mask and clear
  task t_irq;
    w(2);
    `CHK("irq_mask", 1'b0, irq)
    wreg(8'h0c, 32'h2);
    w(1);
    `CHK("irq_on", 1'b1, irq)
    rchk("imask", 8'h0c, 32'h2);
    rchk("istat_set", 8'h08, 32'h7);
    wreg(8'h08, 32'hf);
    rchk("istat", 8'h08, 32'h0);
    `CHK("irq_off", 1'b0, irq)
  endtask
  // External blocking event, then source zero
  task t_blk;
    wreg(8'h00, 32'h10001);
    ev <= 16'h0001;
    m(2'h0, 16'h0064);
    w(6);
    `CHK("blk", 1'b1, fl.blocked)
    `CHK("blk_pick", 1'b0, fl.pickup)
    rchk("istat_blk", 8'h08, 32'h8);
    @(posedge clk);
    ev <= 16'h0;
    w(6);
    `CHK("unblk", 1'b0, fl.blocked)
    `CHK("unblk_pick", 1'b1, fl.pickup)
    wreg(8'h00, 32'h1);
    ev <= 16'h0001;
    w(6);
    `CHK("blk0", 1'b0, fl.blocked)
    `CHK("blk0_pick", 1'b1, fl.pickup)
  endtask
  // Second set, disable and unsupported source
  task t_set;
    wreg(8'h00, 32'h11);
    w(4);
    `CHK("set1_pick", 1'b0, fl.pickup)
    wreg(8'h00, 32'h0);
    w(2);
    `CHK("off", 1'b0, fl.active)
    `CHK("off_t1", 1'b0, fl.trip1)
    wreg(8'h00, 32'h5);
    w(4);
    `CHK("ct2_pick", 1'b0, fl.pickup)
    rchk("status", 8'h04, 32'h21);
    rchk("ctrl5", 8'h00, 32'h5);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reg;
    t_pick;
    t_trip;
    t_irq;
    t_blk;
    t_set;
    summarize;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    summarize;
  end
endmodule // testbench
